// file: ptpc_pkg.sv
// constants shared by the precision time clock and its compare channels
// assumes one clock_i edge per reference period of the time counter

package ptpc_pkg;

   // ************************************************************
   // time format
   // ************************************************************
   localparam int SEC_W = 32;
   localparam int NS_W = 30;
   localparam int SUBNS_W = 32;
   localparam int CHAN_N = 2;

   localparam logic [29:0] NS_PER_SEC = 30'h3B9A_CA00;
   localparam logic [4:0] NS_STEP_NOMINAL = 5'h0A;
   localparam logic [4:0] NS_STEP_SLOW = 5'h09;
   localparam logic [4:0] NS_STEP_FAST = 5'h0B;

   // ************************************************************
   // values after reset
   // ************************************************************
   localparam logic [31:0] RST_SEC = 32'h0000_0000;
   localparam logic [29:0] RST_NS = 30'h0000_0000;
   localparam logic [31:0] RST_SUBNS = 32'h0000_0000;
   localparam logic [1:0] RST_STATUS = 2'h0;

   // ************************************************************
   // temporary rate sequencer
   // ************************************************************
   typedef enum logic [1:0] {
      PTPC_RATE_NORMAL = 2'b01,
      PTPC_RATE_TEMP = 2'b10
   } ptpc_rate_e;

endpackage

// file: ptpc_chan_if.sv
// signals between the time core and one compare channel
// assumes the core drives time and strobes, the channel answers

`timescale 1ns/1ps

interface ptpc_chan_if;
   logic [31:0] sec;
   logic [29:0] ns;
   logic [31:0] wr_data;
   logic wr_tsec;
   logic wr_tns;
   logic wr_rsec;
   logic wr_rns;
   logic reload_add;
   logic target_snap;
   logic event_pulse;
   logic [31:0] rd_sec;
   logic [29:0] rd_ns;

   modport chan (
      input sec, ns, wr_data, wr_tsec, wr_tns, wr_rsec, wr_rns,
      input reload_add, target_snap,
      output event_pulse, rd_sec, rd_ns
   );
   modport core (
      output sec, ns, wr_data, wr_tsec, wr_tns, wr_rsec, wr_rns,
      output reload_add, target_snap,
      input event_pulse, rd_sec, rd_ns
   );
endinterface

// file: ptpc_event_channel.sv
// one compare event channel: target pair, reload/add pair, comparator
// assumes at most one half of a pair is written per cycle

`timescale 1ns/1ps

module ptpc_event_channel
   import ptpc_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   ptpc_chan_if.chan ch_io
);
   logic [31:0] tgt_sec_ff, hold_tsec_ff, rld_sec_ff, hold_rsec_ff;
   logic [29:0] tgt_ns_ff, hold_tns_ff, rld_ns_ff, hold_rns_ff;
   logic pend_tsec_ff, pend_tns_ff, pend_rsec_ff, pend_rns_ff;
   logic [31:0] rd_sec_ff;
   logic [29:0] rd_ns_ff;
   logic armed_ff;

   // ************************************************************
   // paired writes: a pair takes effect once both halves are in
   // ************************************************************
   wire have_tsec = pend_tsec_ff | ch_io.wr_tsec;
   wire have_tns = pend_tns_ff | ch_io.wr_tns;
   wire tgt_commit = have_tsec & have_tns;
   wire [31:0] stage_tsec = ch_io.wr_tsec ? ch_io.wr_data : hold_tsec_ff;
   wire [29:0] stage_tns = ch_io.wr_tns ? ch_io.wr_data[29:0] : hold_tns_ff;
   wire have_rsec = pend_rsec_ff | ch_io.wr_rsec;
   wire have_rns = pend_rns_ff | ch_io.wr_rns;
   wire rld_commit = have_rsec & have_rns;
   wire [31:0] stage_rsec = ch_io.wr_rsec ? ch_io.wr_data : hold_rsec_ff;
   wire [29:0] stage_rns = ch_io.wr_rns ? ch_io.wr_data[29:0] : hold_rns_ff;

   // ************************************************************
   // compare and next target
   // ************************************************************
   // unarmed until software first sets a target, so reset zeros never fire
   wire sec_gt = ch_io.sec > tgt_sec_ff;
   wire sec_eq = ch_io.sec == tgt_sec_ff;
   wire reached = armed_ff & (sec_gt | (sec_eq & (ch_io.ns >= tgt_ns_ff)));
   wire [30:0] add_sum = {1'b0, tgt_ns_ff} + {1'b0, rld_ns_ff};
   wire add_carry = add_sum >= {1'b0, NS_PER_SEC};
   wire [30:0] add_wrap = add_sum - {1'b0, NS_PER_SEC};
   wire [29:0] add_ns = add_carry ? add_wrap[29:0] : add_sum[29:0];
   wire [31:0] add_sec = tgt_sec_ff + rld_sec_ff + {31'h0, add_carry};
   // a software write beats the automatic update in the same cycle
   wire [31:0] nxt_tgt_sec = tgt_commit ? stage_tsec :
      (reached ? (ch_io.reload_add ? rld_sec_ff : add_sec) : tgt_sec_ff);
   wire [29:0] nxt_tgt_ns = tgt_commit ? stage_tns :
      (reached ? (ch_io.reload_add ? rld_ns_ff : add_ns) : tgt_ns_ff);

   assign ch_io.event_pulse = reached;
   assign ch_io.rd_sec = rd_sec_ff;
   assign ch_io.rd_ns = rd_ns_ff;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tgt_sec_ff <= RST_SEC;
         tgt_ns_ff <= RST_NS;
         rld_sec_ff <= RST_SEC;
         rld_ns_ff <= RST_NS;
         hold_tsec_ff <= RST_SEC;
         hold_tns_ff <= RST_NS;
         hold_rsec_ff <= RST_SEC;
         hold_rns_ff <= RST_NS;
         pend_tsec_ff <= 1'b0;
         pend_tns_ff <= 1'b0;
         pend_rsec_ff <= 1'b0;
         pend_rns_ff <= 1'b0;
         rd_sec_ff <= RST_SEC;
         rd_ns_ff <= RST_NS;
         armed_ff <= 1'b0;
      end else begin
         tgt_sec_ff <= nxt_tgt_sec;
         tgt_ns_ff <= nxt_tgt_ns;
         hold_tsec_ff <= stage_tsec;
         hold_tns_ff <= stage_tns;
         hold_rsec_ff <= stage_rsec;
         hold_rns_ff <= stage_rns;
         pend_tsec_ff <= have_tsec & ~tgt_commit;
         pend_tns_ff <= have_tns & ~tgt_commit;
         pend_rsec_ff <= have_rsec & ~rld_commit;
         pend_rns_ff <= have_rns & ~rld_commit;
         if (rld_commit) begin
            rld_sec_ff <= stage_rsec;
            rld_ns_ff <= stage_rns;
         end
         if (ch_io.target_snap) begin
            rd_sec_ff <= tgt_sec_ff;
            rd_ns_ff <= tgt_ns_ff;
         end
         armed_ff <= armed_ff | tgt_commit;
      end
   end

   chk_pair_commit: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (ch_io.wr_tsec && pend_tns_ff) |=> (tgt_sec_ff == $past(ch_io.wr_data)
      && tgt_ns_ff == $past(hold_tns_ff) && armed_ff))
      else $error("target pair did not commit on second half");
   chk_reload_load: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (reached && ch_io.reload_add && !tgt_commit) |=>
      (tgt_sec_ff == $past(rld_sec_ff) && tgt_ns_ff == $past(rld_ns_ff)))
      else $error("reload did not load next target");
   chk_add_carry: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (reached && !ch_io.reload_add && !tgt_commit && add_carry) |=>
      (tgt_sec_ff == $past(tgt_sec_ff) + $past(rld_sec_ff) + 32'h0000_0001))
      else $error("add mode lost the nanosecond carry");
endmodule

// file: ptpc_time_clock.sv
// precision time clock with rate trim, steps, temporary rate and
// two compare event channels; all controls are plain ports
// assumes command inputs are one-cycle pulses synchronous to clock_i

`timescale 1ns/1ps

module ptpc_time_clock
   import ptpc_pkg::*;
#(
   parameter int TEMP_DUR_W = 32
)
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   // commands, one-cycle pulses
   input wire logic cmd_snapshot_i,
   input wire logic cmd_load_i,
   input wire logic cmd_step_sec_i,
   input wire logic cmd_step_ns_i,
   input wire logic cmd_temp_rate_i,
   input wire logic cmd_target_snap_i,
   // load values
   input wire logic [31:0] load_seconds_i,
   input wire logic [29:0] load_nanoseconds_i,
   input wire logic [31:0] load_subnano_i,
   // rate and step settings
   input wire logic [31:0] rate_trim_amount_i,
   input wire logic rate_trim_direction_i,
   input wire logic [31:0] temp_rate_amount_i,
   input wire logic temp_rate_direction_i,
   input wire logic [TEMP_DUR_W-1:0] temp_rate_duration_i,
   input wire logic [31:0] time_step_amount_i,
   input wire logic time_step_direction_i,
   // compare channel configuration
   input wire logic [31:0] chan_wr_data_i,
   input wire logic [1:0] wr_target_seconds_i,
   input wire logic [1:0] wr_target_nanoseconds_i,
   input wire logic [1:0] wr_increment_seconds_i,
   input wire logic [1:0] wr_increment_nanoseconds_i,
   input wire logic [1:0] reload_add_i,
   input wire logic [1:0] status_clear_i,
   // readable state
   output logic [31:0] time_seconds_value_o,
   output logic [29:0] time_nanoseconds_value_o,
   output logic [31:0] time_subnano_value_o,
   output logic temp_rate_active_o,
   output logic [1:0][31:0] compare_target_seconds_o,
   output logic [1:0][29:0] compare_target_nanoseconds_o,
   output logic [1:0] time_event_status_o
);

   // ************************************************************
   // parameter check
   // ************************************************************
   if (TEMP_DUR_W < 1 || TEMP_DUR_W > 32) begin : g_bad_width
      $error("TEMP_DUR_W must lie in 1..32");
   end

   // ************************************************************
   // state
   // ************************************************************
   logic [31:0] sec_ff;
   logic [29:0] ns_ff;
   logic [31:0] subns_ff;
   logic [31:0] snap_sec_ff;
   logic [29:0] snap_ns_ff;
   logic [31:0] snap_subns_ff;
   ptpc_rate_e rate_state_ff, nxt_rate_state;
   logic [TEMP_DUR_W-1:0] temp_count_ff, nxt_temp_count;
   logic [1:0] status_ff;
   logic [1:0] chan_event;
   logic [1:0][31:0] chan_rd_sec;
   logic [1:0][29:0] chan_rd_ns;

   // ************************************************************
   // rate selection and sub-nanosecond accumulator
   // ************************************************************
   wire temp_on = rate_state_ff == PTPC_RATE_TEMP;
   wire [31:0] rate_amt = temp_on ? temp_rate_amount_i : rate_trim_amount_i;
   wire rate_fast = temp_on ? temp_rate_direction_i : rate_trim_direction_i;
   wire [32:0] sub_sum = {1'b0, subns_ff} + {1'b0, rate_amt};
   wire sub_wrap = sub_sum[32];
   wire [31:0] nxt_subns_run = sub_sum[31:0];

   // the normal increment; a wrap picks 9 or 11 by direction
   wire [4:0] tick_inc = sub_wrap ?
      (rate_fast ? NS_STEP_FAST : NS_STEP_SLOW) : NS_STEP_NOMINAL;

   // ************************************************************
   // nanoseconds path
   // ************************************************************
   // a nanosecond step replaces the tick increment for one cycle
   wire [31:0] ns_add = cmd_step_ns_i ?
      time_step_amount_i : {27'h0, tick_inc};
   wire [32:0] ns_sum = {3'h0, ns_ff} + {1'b0, ns_add};
   wire ns_roll = ns_sum >= {3'h0, NS_PER_SEC};
   wire [32:0] ns_wrap = ns_sum - {3'h0, NS_PER_SEC};
   // limitation: a step above one second is folded only once
   wire [29:0] nxt_ns_run = ns_roll ? ns_wrap[29:0] : ns_sum[29:0];

   // ************************************************************
   // seconds path
   // ************************************************************
   wire [31:0] step_signed = time_step_direction_i ?
      time_step_amount_i : (32'h0 - time_step_amount_i);
   wire [31:0] sec_step = cmd_step_sec_i ? step_signed : 32'h0;
   // step and rollover carry add together in the same cycle
   wire [31:0] nxt_sec_run = sec_ff + sec_step + {31'h0, ns_roll};

   // ************************************************************
   // next time, load has priority over running
   // ************************************************************
   wire [31:0] nxt_sec = cmd_load_i ? load_seconds_i : nxt_sec_run;
   wire [29:0] nxt_ns = cmd_load_i ? load_nanoseconds_i : nxt_ns_run;
   // ns step holds the accumulator, so any wrap in this cycle is dropped
   wire [31:0] nxt_subns = cmd_load_i ? load_subnano_i :
      (cmd_step_ns_i ? subns_ff : nxt_subns_run);

   // ************************************************************
   // temporary rate sequencer
   // ************************************************************
   // a zero duration never enters the temporary state
   wire temp_start = cmd_temp_rate_i && (temp_rate_duration_i != '0);
   wire temp_last = temp_count_ff == {{(TEMP_DUR_W-1){1'b0}}, 1'b1};

   always_comb begin
      nxt_rate_state = rate_state_ff;
      nxt_temp_count = temp_count_ff;
      case (rate_state_ff)
         PTPC_RATE_NORMAL: begin
            if (temp_start) begin
               nxt_rate_state = PTPC_RATE_TEMP;
               nxt_temp_count = temp_rate_duration_i;
            end
         end
         PTPC_RATE_TEMP: begin
            nxt_temp_count = temp_count_ff - {{(TEMP_DUR_W-1){1'b0}}, 1'b1};
            if (temp_last) begin
               nxt_rate_state = PTPC_RATE_NORMAL;
            end
         end
         default: begin
            nxt_rate_state = PTPC_RATE_NORMAL;
            nxt_temp_count = '0;
         end
      endcase
   end

   // ************************************************************
   // event status, set wins over clear
   // ************************************************************
   wire [1:0] nxt_status = (status_ff & ~status_clear_i) | chan_event;

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sec_ff <= RST_SEC;
         ns_ff <= RST_NS;
         subns_ff <= RST_SUBNS;
         rate_state_ff <= PTPC_RATE_NORMAL;
         temp_count_ff <= '0;
         status_ff <= RST_STATUS;
      end else begin
         sec_ff <= nxt_sec;
         ns_ff <= nxt_ns;
         subns_ff <= nxt_subns;
         rate_state_ff <= nxt_rate_state;
         temp_count_ff <= nxt_temp_count;
         status_ff <= nxt_status;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         snap_sec_ff <= RST_SEC;
         snap_ns_ff <= RST_NS;
         snap_subns_ff <= RST_SUBNS;
      end else if (cmd_snapshot_i) begin
         snap_sec_ff <= sec_ff;
         snap_ns_ff <= ns_ff;
         snap_subns_ff <= subns_ff;
      end
   end

   // ************************************************************
   // compare channels
   // ************************************************************
   for (genvar c = 0; c < CHAN_N; c++) begin : g_chan
      ptpc_chan_if u_link();

      assign u_link.sec = sec_ff;
      assign u_link.ns = ns_ff;
      assign u_link.wr_data = chan_wr_data_i;
      assign u_link.wr_tsec = wr_target_seconds_i[c];
      assign u_link.wr_tns = wr_target_nanoseconds_i[c];
      assign u_link.wr_rsec = wr_increment_seconds_i[c];
      assign u_link.wr_rns = wr_increment_nanoseconds_i[c];
      assign u_link.reload_add = reload_add_i[c];
      assign u_link.target_snap = cmd_target_snap_i;
      assign chan_event[c] = u_link.event_pulse;
      assign chan_rd_sec[c] = u_link.rd_sec;
      assign chan_rd_ns[c] = u_link.rd_ns;

      ptpc_event_channel u_chan (
         .clock_i(clock_i),
         .rst_n_i(rst_n_i),
         .ch_io(u_link.chan)
      );
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign time_seconds_value_o = snap_sec_ff;
   assign time_nanoseconds_value_o = snap_ns_ff;
   assign time_subnano_value_o = snap_subns_ff;
   assign temp_rate_active_o = temp_on;
   assign compare_target_seconds_o = chan_rd_sec;
   assign compare_target_nanoseconds_o = chan_rd_ns;
   assign time_event_status_o = status_ff;

   // ************************************************************
   // checks
   // ************************************************************
   wire quiet = !cmd_load_i && !cmd_step_ns_i && !cmd_step_sec_i;

   chk_ns_range: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      !$past(cmd_load_i) |-> ns_ff < NS_PER_SEC)
      else $error("nanoseconds left the one second range");

   chk_normal_tick: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (quiet && !sub_wrap && !ns_roll) |=>
      ns_ff == $past(ns_ff) + 30'h0000_000A)
      else $error("normal tick did not add ten");

   chk_rollover: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (quiet && ns_roll) |=> (sec_ff == $past(sec_ff) + 32'h0000_0001
      && ns_ff == 30'($past(ns_ff) + $past(ns_add) - NS_PER_SEC)))
      else $error("rollover did not carry into seconds");

   chk_snapshot: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      cmd_snapshot_i |=> (time_seconds_value_o == $past(sec_ff)
      && time_nanoseconds_value_o == $past(ns_ff)
      && time_subnano_value_o == $past(subns_ff)))
      else $error("snapshot did not capture the time");

   chk_trim_step: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (quiet && sub_wrap && !ns_roll) |=> ns_ff == $past(ns_ff) +
      ($past(rate_fast) ? 30'h0000_000B : 30'h0000_0009))
      else $error("accumulator wrap did not pick 9 or 11");

   chk_load_apply: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      cmd_load_i |=> (sec_ff == $past(load_seconds_i)
      && ns_ff == $past(load_nanoseconds_i)
      && subns_ff == $past(load_subnano_i)))
      else $error("load did not replace the time");

   chk_sec_step: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (cmd_step_sec_i && !cmd_load_i && !cmd_step_ns_i) |=>
      (sec_ff == $past(sec_ff) + $past(step_signed)
      + {31'h0, $past(ns_roll)}))
      else $error("seconds step applied wrongly");

   chk_ns_step_hold: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (cmd_step_ns_i && !cmd_load_i && time_step_amount_i == 32'h0) |=>
      (ns_ff == $past(ns_ff) && subns_ff == $past(subns_ff)))
      else $error("zero ns step did not pause the clock");

   chk_temp_expire: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (temp_on && temp_last) |=> !temp_rate_active_o)
      else $error("temporary rate did not self clear");

   chk_status_set: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      chan_event[0] |=> time_event_status_o[0])
      else $error("compare event did not set its status bit");

   chk_status_set_b: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      chan_event[1] |=> time_event_status_o[1])
      else $error("second channel event did not set its status bit");

   chk_status_clear: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (status_clear_i[0] && !chan_event[0]) |=> !time_event_status_o[0])
      else $error("status clear did not take effect");

   chk_accum_add: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (!temp_on && !cmd_load_i && !cmd_step_ns_i) |=>
      subns_ff == 32'($past(subns_ff) + $past(rate_trim_amount_i)))
      else $error("accumulator did not add the rate trim");

   chk_temp_accum: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (temp_on && !cmd_load_i && !cmd_step_ns_i) |=>
      subns_ff == 32'($past(subns_ff) + $past(temp_rate_amount_i)))
      else $error("temporary rate was not used while active");

   chk_temp_start: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (!temp_on && cmd_temp_rate_i && temp_rate_duration_i != '0) |=>
      (temp_rate_active_o && temp_count_ff == $past(temp_rate_duration_i)))
      else $error("temporary rate did not start");

   chk_ns_step_add: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (cmd_step_ns_i && !cmd_load_i && !ns_roll) |=>
      ns_ff == 30'($past(ns_ff) + $past(time_step_amount_i)))
      else $error("nanosecond step did not replace the tick");

   chk_step_wrap: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (cmd_step_ns_i && !cmd_load_i && !cmd_step_sec_i && ns_roll) |=>
      sec_ff == $past(sec_ff) + 32'h0000_0001)
      else $error("nanosecond step wrap did not bump seconds");
endmodule

// file: ptpc_time_clock_tb.sv
// self-checking bench for the precision time clock and its two channels
// assumes the design is reached only through its plain ports

`timescale 1ns/1ps

`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end

module ptpc_time_clock_tb;
   import ptpc_pkg::*;
   // ************************************************************
   // stimulus and observed signals
   // ************************************************************
   localparam logic [5:0] SNAP = 6'h01, LOAD = 6'h02, STEPS = 6'h04;
   localparam logic [5:0] STEPN = 6'h08, TEMP = 6'h10, TSNAP = 6'h20;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [5:0] cmd = '0;
   logic [31:0] ld_s = '0, ld_sub = '0, rate = '0, trate = '0, stp = '0;
   logic [29:0] ld_n = '0;
   logic rdir = 1'b0, tdir = 1'b0, sdir = 1'b0;
   logic [7:0] dur = 8'h04;
   logic [31:0] wdata = '0;
   logic [1:0] wts = '0, wtn = '0, wis = '0, win = '0, rld = '0, sclr = '0;
   logic [31:0] o_s, o_sub;
   logic [29:0] o_n;
   logic o_tact;
   logic [1:0][31:0] o_ts;
   logic [1:0][29:0] o_tn;
   logic [1:0] o_st;
   int failures = 0, comparisons = 0;

   always #2 clock_i = ~clock_i;

   ptpc_time_clock #(.TEMP_DUR_W(8)) DUT (
      .clock_i(clock_i), .rst_n_i(rst_n_i),
      .cmd_snapshot_i(cmd[0]), .cmd_load_i(cmd[1]),
      .cmd_step_sec_i(cmd[2]), .cmd_step_ns_i(cmd[3]),
      .cmd_temp_rate_i(cmd[4]), .cmd_target_snap_i(cmd[5]),
      .load_seconds_i(ld_s), .load_nanoseconds_i(ld_n),
      .load_subnano_i(ld_sub),
      .rate_trim_amount_i(rate), .rate_trim_direction_i(rdir),
      .temp_rate_amount_i(trate), .temp_rate_direction_i(tdir),
      .temp_rate_duration_i(dur),
      .time_step_amount_i(stp), .time_step_direction_i(sdir),
      .chan_wr_data_i(wdata), .wr_target_seconds_i(wts),
      .wr_target_nanoseconds_i(wtn), .wr_increment_seconds_i(wis),
      .wr_increment_nanoseconds_i(win), .reload_add_i(rld),
      .status_clear_i(sclr),
      .time_seconds_value_o(o_s), .time_nanoseconds_value_o(o_n),
      .time_subnano_value_o(o_sub), .temp_rate_active_o(o_tact),
      .compare_target_seconds_o(o_ts),
      .compare_target_nanoseconds_o(o_tn),
      .time_event_status_o(o_st)
   );
   // ************************************************************
   // access tasks
   // ************************************************************
   // strobes stay up until the next call or wait, so none is set twice
   // in one time step; every wait lowers them first
   task automatic tick(input int n);
      if (n > 0) begin
         cmd = '0;
         {wts, wtn, wis, win} = '0;
         repeat (n) @(posedge clock_i);
         #1;
      end
   endtask
   task automatic go(input logic [5:0] c);
      cmd = c;
      {wts, wtn, wis, win} = '0;
      @(posedge clock_i);
      #1;
   endtask
   task automatic load(input logic [31:0] s, input logic [29:0] n,
                       input logic [31:0] sub);
      ld_s = s;
      ld_n = n;
      ld_sub = sub;
      go(LOAD);
   endtask
   // snapshot k edges after the previous command; shows pre-edge time
   task automatic snap(input int k, input logic [31:0] s,
                       input logic [29:0] n);
      tick(k - 1);
      go(SNAP);
      `CHK(o_s, s)
      `CHK(o_n, n)
   endtask
   // halves share one data bus, so only one strobe is raised per cycle
   task automatic wr(input int k, input int c, input logic [31:0] d);
      wdata = d;
      cmd = '0;
      {wts, wtn, wis, win} = 8'h01 << ((3 - k) * 2 + c);
      @(posedge clock_i);
      #1;
   endtask
   task automatic summarize();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ************************************************************
   // tests
   // ************************************************************
   initial begin
      #20000;
      failures++;
      summarize();
   end
   initial begin
      repeat (8) @(posedge clock_i);
      #1;
      rst_n_i = 1'b1;
      `CHK({o_s, o_n, o_sub, o_tact, o_ts, o_tn, o_st}, '0)
      rld = 2'b01;
      wr(3, 0, 32'h0000_0007);
      wr(2, 0, 32'h0000_0014);
      wr(0, 0, 32'h0000_000A);
      wr(1, 0, 32'h0000_0032);
      wr(1, 1, 32'h0000_003C);
      wr(0, 1, 32'h0000_000A);
      wr(2, 1, 32'h0000_0001);
      wr(3, 1, 32'(NS_PER_SEC - 30'h14));
      `CHK(o_st, 2'b00)
      load(32'h0000_000A, 30'h0, 32'h0);
      tick(20);
      `CHK(o_st, 2'b11)
      go(TSNAP);
      `CHK(o_ts[0], 32'h0000_0014)
      `CHK(o_tn[0], 30'h7)
      `CHK(o_ts[1], 32'h0000_000C)
      `CHK(o_tn[1], 30'h28)
      sclr = 2'b01;
      tick(1);
      sclr = 2'b00;
      `CHK(o_st, 2'b10)
      $display("test channels done");
      load(32'h0000_0005, NS_PER_SEC - 30'h19, 32'h0);
      snap(1, 32'h0000_0005, NS_PER_SEC - 30'h19);
      snap(3, 32'h0000_0006, 30'h5);
      $display("test rollover done");
      stp = 32'h0000_0003;
      sdir = 1'b1;
      load(32'h0000_0009, NS_PER_SEC - 30'hA, 32'h1234_5678);
      go(STEPS);
      snap(1, 32'h0000_000D, 30'h0);
      stp = 32'h0000_0005;
      sdir = 1'b0;
      go(STEPS);
      snap(1, 32'h0000_0008, 30'h14);
      `CHK(o_sub, 32'h1234_5678)
      $display("test seconds step done");
      rate = 32'h8000_0000;
      rdir = 1'b1;
      stp = '0;
      load(32'h0000_0002, 30'h64, 32'h8000_0000);
      go(STEPN);
      snap(1, 32'h0000_0002, 30'h64);
      `CHK(o_sub, 32'h8000_0000)
      stp = 32'h0000_0014;
      load(32'h0000_0002, NS_PER_SEC - 30'h5, 32'h0);
      go(STEPN);
      snap(1, 32'h0000_0003, 30'hF);
      $display("test nanosecond step done");
      load(32'h0, 30'h0, 32'h0);
      snap(1, 32'h0, 30'h0);
      snap(2, 32'h0, 30'h15);
      `CHK(o_sub, 32'h0)
      rdir = 1'b0;
      snap(2, 32'h0, 30'h28);
      $display("test rate trim done");
      rate = '0;
      trate = 32'h8000_0000;
      tdir = 1'b1;
      load(32'h0, 30'h0, 32'h0);
      go(TEMP);
      `CHK(o_tact, 1'b1)
      snap(6, 32'h0, 30'h3E);
      `CHK(o_tact, 1'b0)
      $display("test temporary rate done");
      summarize();
   end
endmodule
